// ### dv/mbac_cpu_model.sv
// Register file model that the checker forwards register traffic to
`timescale 1ns/100ps
`default_nettype none

module mbac_cpu_model (
	// Clock
	input  wire logic       core_clk,
	// Lookup and forwarded writes
	input  wire logic [7:0] sfrAddr,
	input  wire logic       sfrWrStb,
	input  wire logic [7:0] sfrWrAddr,
	input  wire logic [7:0] sfrWrData,
	output logic      [7:0] sfrRegData
);
	logic [7:0] regs [256];

	// Address dependent contents expose a wrong register lookup
	initial begin
		for (int i = 0; i < 256; i++) begin
			regs[i] = 8'(i) ^ 8'h5A;
		end
	end

	always @(posedge core_clk) begin
		if (sfrWrStb) begin
			regs[sfrWrAddr] <= sfrWrData;
		end
	end

	assign sfrRegData = regs[sfrAddr];
endmodule

`default_nettype wire

// ### dv/mode_based_access_control_tb.sv
// Self-checking testbench for the mode based access control block
`timescale 1ns/100ps
`default_nettype none
`include "mbac_defs.svh"
`define CHK(g, e) begin samplesChecked++; if ((g) !== (e)) begin mismatches++; $display("Error at %0t: got %h, expected %h", $time, g, e); end end

module mode_based_access_control_tb import mbac_pkg::*;;
	logic        core_clk       = 1'b0;
	logic        arst_n         = 1'b0;
	logic        bootDone       = 1'b0;
	logic        cfgValid       = 1'b1;
	logic [15:0] cfgTestRomEnd  = 16'h1000;
	logic [15:0] cfgSecRowBase  = 16'hF000;
	logic [15:0] cfgFabKeyLo    = 16'hF000;
	logic [15:0] cfgFabKeyHi    = 16'hF00F;
	logic [15:0] cfgSecRdLo     = 16'hF100;
	logic [15:0] cfgSecRdHi     = 16'hF10F;
	logic        memReq         = 1'b0;
	mbac_space_t memSpace       = SPC_ROM;
	mbac_op_t    memOp          = OP_READ;
	logic [15:0] memAddr        = 16'h0000;
	logic        sfrReq         = 1'b0;
	logic        sfrWe          = 1'b0;
	logic [7:0]  sfrAddr        = 8'h00;
	logic [7:0]  sfrWdata       = 8'h00;
	logic        memGrant;
	logic        memDeny;
	logic        sfrAck;
	logic [7:0]  sfrRdata;
	logic [7:0]  sfrRegData;
	logic        sfrWrStb;
	logic [7:0]  sfrWrAddr;
	logic [7:0]  sfrWrData;
	logic        privMode;
	logic        cfgLoaded;
	logic        secViol;
	logic        sysRstReq;
	int          mismatches     = 0;
	int          samplesChecked = 0;
	int          cycles         = 0;

	mbac_top dut_u (.core_clk, .arst_n, .bootDone, .cfgValid, .cfgTestRomEnd,
		.cfgSecRowBase, .cfgFabKeyLo, .cfgFabKeyHi, .cfgSecRdLo, .cfgSecRdHi,
		.memReq, .memSpace, .memOp, .memAddr, .memGrant, .memDeny, .sfrReq, .sfrWe,
		.sfrAddr, .sfrWdata, .sfrAck, .sfrRdata, .sfrRegData, .sfrWrStb, .sfrWrAddr,
		.sfrWrData, .privMode, .cfgLoaded, .secViol, .sysRstReq);
	mbac_cpu_model cpu_u (.core_clk, .sfrAddr, .sfrWrStb, .sfrWrAddr, .sfrWrData,
		.sfrRegData);

	always #25 core_clk = ~core_clk;

	// Whole run needs well under a thousand cycles
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			end_sim();
		end
	end

	////////////////////////////////////////////////////////////////////
	task automatic end_sim();
		if (mismatches == 0 && samplesChecked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic do_reset();
		arst_n = 1'b0;
		repeat (6) @(negedge core_clk);
		arst_n = 1'b1;
		@(negedge core_clk);
	endtask

	// Request at one falling edge, answer judged at the next, then one idle cycle
	task automatic mem(input mbac_space_t sp, input mbac_op_t op,
		input logic [15:0] ad, input logic ok);
		memReq = 1'b1;
		memSpace = sp;
		memOp = op;
		memAddr = ad;
		@(negedge core_clk);
		memReq = 1'b0;
		`CHK(memGrant, ok)
		`CHK(memDeny, ~ok)
		@(negedge core_clk);
		`CHK(memGrant, 1'b0)
		`CHK(memDeny, 1'b0)
	endtask

	task automatic sfr(input logic we, input logic [7:0] ad, input logic [7:0] wd,
		input logic [7:0] rd, input logic stb);
		sfrReq = 1'b1;
		sfrWe = we;
		sfrAddr = ad;
		sfrWdata = wd;
		@(negedge core_clk);
		sfrReq = 1'b0;
		`CHK(sfrAck, 1'b1)
		`CHK(sfrRdata, rd)
		`CHK(sfrWrStb, stb)
		if (stb) `CHK(sfrWrData, wd)
		if (stb) `CHK(sfrWrAddr, ad)
		@(negedge core_clk);
		`CHK(sfrAck, 1'b0)
		`CHK(sfrRdata, 8'h00)
		`CHK(sfrWrStb, 1'b0)
	endtask

	////////////////////////////////////////////////////////////////////
	task automatic t_priv();
		do_reset();
		`CHK(privMode, 1'b1)
		`CHK(cfgLoaded, 1'b1)
		mem(SPC_ROM, OP_READ, 16'h0000, 1'b1);
		mem(SPC_ROM, OP_EXEC, 16'h0FFF, 1'b1);
		mem(SPC_ROM, OP_WRITE, 16'h2000, 1'b0);
		mem(SPC_EE, OP_EXEC, 16'h0100, 1'b1);
		mem(SPC_EE, OP_WRITE, 16'hF200, 1'b1);
		mem(SPC_RAM, OP_WRITE, 16'h0040, 1'b1);
		mem(SPC_RAM, OP_EXEC, 16'h0040, 1'b0);
		sfr(1'b0, `MBAC_SFR_CFG_LO, 8'h00, `MBAC_SFR_CFG_LO ^ 8'h5A, 1'b0);
		sfr(1'b1, `MBAC_SFR_TEST_HI, 8'h3C, 8'h00, 1'b1);
		for (int a = 8'hA1; a <= 8'hA5; a++) begin
			sfr(1'b0, 8'(a), 8'h00, 8'h00, 1'b0);
		end
		sfr(1'b1, `MBAC_SFR_PROT_A0, 8'hC3, 8'h00, 1'b1);
	endtask

	task automatic t_user();
		bootDone = 1'b1;
		@(negedge core_clk);
		bootDone = 1'b0;
		`CHK(privMode, 1'b0)
		repeat (3) @(negedge core_clk);
		`CHK(privMode, 1'b0)
		mem(SPC_ROM, OP_READ, 16'h0FFF, 1'b0);
		mem(SPC_ROM, OP_EXEC, 16'h1000, 1'b1);
		mem(SPC_EE, OP_EXEC, 16'h0100, 1'b0);
		mem(SPC_EE, OP_WRITE, 16'hEFFF, 1'b1);
		mem(SPC_EE, OP_WRITE, 16'hF000, 1'b0);
		mem(SPC_EE, OP_READ, 16'hF00F, 1'b1);
		mem(SPC_EE, OP_READ, 16'hF10F, 1'b1);
		mem(SPC_EE, OP_READ, 16'hF080, 1'b0);
		mem(SPC_RAM, OP_WRITE, 16'hFFFF, 1'b1);
		mem(SPC_RAM, OP_READ, 16'h0000, 1'b1);
		sfr(1'b0, `MBAC_SFR_CFG_LO, 8'h00, 8'h00, 1'b0);
		sfr(1'b0, `MBAC_SFR_TEST_LO, 8'h00, 8'h00, 1'b0);
		sfr(1'b0, `MBAC_SFR_RNG_OUT, 8'h00, `MBAC_SFR_RNG_OUT ^ 8'h5A, 1'b0);
		sfr(1'b1, `MBAC_SFR_CPU_HI, 8'h99, 8'h00, 1'b1);
		sfr(1'b0, 8'h7F, 8'h00, 8'h00, 1'b0);
		`CHK(secViol, 1'b0)
		sfr(1'b1, `MBAC_SFR_CFG_HI, 8'h11, 8'h00, 1'b0);
		`CHK(secViol, 1'b1)
		`CHK(sysRstReq, 1'b1)
		mem(SPC_RAM, OP_READ, 16'h0000, 1'b0);
		sfr(1'b0, `MBAC_SFR_CPU_HI, 8'h00, 8'h00, 1'b0);
	endtask

	task automatic t_faults();
		do_reset();
		`CHK(privMode, 1'b1)
		`CHK(secViol, 1'b0)
		sfr(1'b1, 8'h00, 8'h55, 8'h00, 1'b0);
		`CHK(sysRstReq, 1'b1)
		do_reset();
		sfr(1'b1, `MBAC_SFR_RNG_OUT, 8'h01, 8'h00, 1'b0);
		`CHK(secViol, 1'b1)
	endtask

	// Late partition values and early boot completion
	task automatic t_cfg();
		cfgValid = 1'b0;
		bootDone = 1'b1;
		do_reset();
		`CHK(cfgLoaded, 1'b0)
		`CHK(privMode, 1'b1)
		cfgTestRomEnd = 16'h2000;
		cfgValid = 1'b1;
		@(negedge core_clk);
		`CHK(cfgLoaded, 1'b1)
		`CHK(privMode, 1'b1)
		cfgTestRomEnd = 16'h3000;
		@(negedge core_clk);
		bootDone = 1'b0;
		`CHK(privMode, 1'b0)
		mem(SPC_ROM, OP_READ, 16'h1FFF, 1'b0);
		mem(SPC_ROM, OP_READ, 16'h2000, 1'b1);
	endtask

	initial begin
		t_priv();
		t_user();
		t_faults();
		t_cfg();
		end_sim();
	end
endmodule

`default_nettype wire

// ### include/mbac_defs.svh
// Constants for the mode based access control block
`ifndef MBAC_DEFS_SVH
`define MBAC_DEFS_SVH

// Bus widths
`define MBAC_MEM_AW          16
`define MBAC_SFR_AW          8
`define MBAC_SFR_DW          8

// Special function register groups, inclusive bounds
`define MBAC_SFR_IMPL_LO     8'h80
`define MBAC_SFR_CFG_LO      8'h80
`define MBAC_SFR_CFG_HI      8'h8F
`define MBAC_SFR_TEST_LO     8'h90
`define MBAC_SFR_TEST_HI     8'h9F
`define MBAC_SFR_HW_LO       8'hA0
`define MBAC_SFR_HW_HI       8'hDF
`define MBAC_SFR_CPU_LO      8'hE0
`define MBAC_SFR_CPU_HI      8'hFF

// Registers with fixed restrictions
`define MBAC_SFR_RNG_OUT     8'hA0
`define MBAC_SFR_CIPHER_KEY  8'hA1
`define MBAC_SFR_PROT_A0     8'hA2
`define MBAC_SFR_PROT_A1     8'hA3
`define MBAC_SFR_PROT_B0     8'hA4
`define MBAC_SFR_PROT_B1     8'hA5

// Reset values of the partition bounds before they are loaded, and of the register data outputs
`define MBAC_RST_ADDR        16'hFFFF
`define MBAC_RST_DATA        8'h00

`endif

// ### include/mbac_pkg.sv
// Types shared by the mode based access control block
package mbac_pkg;

	typedef enum logic [2:0] {
		ST_SYS  = 3'b001,
		ST_USR  = 3'b010,
		ST_HALT = 3'b100
	} mbac_mode_t;

	typedef enum logic [1:0] {
		SPC_ROM = 2'b00,
		SPC_EE  = 2'b01,
		SPC_RAM = 2'b10
	} mbac_space_t;

	typedef enum logic [1:0] {
		OP_READ  = 2'b00,
		OP_WRITE = 2'b01,
		OP_EXEC  = 2'b10
	} mbac_op_t;

endpackage

// ### rtl/mbac_sfr_perm.sv
// Per register permission table for special function registers
`timescale 1ns/100ps
`default_nettype none
`include "mbac_defs.svh"

module mbac_sfr_perm import mbac_pkg::*; #(
	parameter int AW = `MBAC_SFR_AW
) (
	// Lookup
	input  wire logic [AW-1:0] sfrAddr,
	input  wire logic          privMode,
	// Decision
	output logic               sfrImpl,
	output logic               sfrRdOk,
	output logic               sfrWrOk
);

	localparam int N = 2 ** AW;

	logic [N-1:0] implVec;
	logic [N-1:0] rdVec;
	logic [N-1:0] wrVec;

	// One decision per register address
	genvar gi;
	generate
		for (gi = 0; gi < N; gi++) begin : gReg
			localparam logic [AW-1:0] A = AW'(gi);
			localparam bit IMPL = A >= `MBAC_SFR_IMPL_LO;
			localparam bit USRGRP = (A >= `MBAC_SFR_HW_LO);
			localparam bit NORD = (A >= `MBAC_SFR_CIPHER_KEY) && (A <= `MBAC_SFR_PROT_B1);
			localparam bit RDONLY = (A == `MBAC_SFR_RNG_OUT);
			logic modeOk;
			assign modeOk = privMode || USRGRP;
			assign implVec[gi] = IMPL;
			assign rdVec[gi] = IMPL && modeOk && !NORD;
			assign wrVec[gi] = IMPL && modeOk && !RDONLY;
		end
	endgenerate

	assign sfrImpl = implVec[sfrAddr];
	assign sfrRdOk = rdVec[sfrAddr];
	assign sfrWrOk = wrVec[sfrAddr];

endmodule
`default_nettype wire

// ### rtl/mbac_top.sv
// Mode based access control for memory and special function register accesses
`timescale 1ns/100ps
`default_nettype none
`include "mbac_defs.svh"

module mbac_top import mbac_pkg::*; #(
	parameter int MAW = `MBAC_MEM_AW,
	parameter int SAW = `MBAC_SFR_AW,
	parameter int SDW = `MBAC_SFR_DW
) (
	// Clock and reset
	input  wire logic           core_clk,
	input  wire logic           arst_n,
	// Boot status
	input  wire logic           bootDone,
	// Partition values from the security row
	input  wire logic           cfgValid,
	input  wire logic [MAW-1:0] cfgTestRomEnd,
	input  wire logic [MAW-1:0] cfgSecRowBase,
	input  wire logic [MAW-1:0] cfgFabKeyLo,
	input  wire logic [MAW-1:0] cfgFabKeyHi,
	input  wire logic [MAW-1:0] cfgSecRdLo,
	input  wire logic [MAW-1:0] cfgSecRdHi,
	// Memory access check
	input  wire logic           memReq,
	input  wire mbac_space_t    memSpace,
	input  wire mbac_op_t       memOp,
	input  wire logic [MAW-1:0] memAddr,
	output logic                memGrant,
	output logic                memDeny,
	// Register access from the CPU
	input  wire logic           sfrReq,
	input  wire logic           sfrWe,
	input  wire logic [SAW-1:0] sfrAddr,
	input  wire logic [SDW-1:0] sfrWdata,
	output logic                sfrAck,
	output logic [SDW-1:0]      sfrRdata,
	// Register file side
	input  wire logic [SDW-1:0] sfrRegData,
	output logic                sfrWrStb,
	output logic [SAW-1:0]      sfrWrAddr,
	output logic [SDW-1:0]      sfrWrData,
	// Mode and security status
	output logic                privMode,
	output logic                cfgLoaded,
	output logic                secViol,
	output logic                sysRstReq
);

	////////////////////////////////////////////////////////////////////////////
	// Mode state

	mbac_mode_t state_r;
	mbac_mode_t state_nxt;
	logic       isPriv;
	logic       isUsr;
	logic       wrFault;

	assign isPriv = (state_r == ST_SYS);
	assign isUsr  = (state_r == ST_USR);

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_SYS: begin
				if (wrFault) begin
					state_nxt = ST_HALT;
				end else if (bootDone && cfgLoaded) begin
					state_nxt = ST_USR;
				end
			end
			ST_USR: begin
				// No exit back to privileged except by reset
				if (wrFault) begin
					state_nxt = ST_HALT;
				end
			end
			ST_HALT: state_nxt = ST_HALT;
			default: state_nxt = ST_HALT;
		endcase
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_r <= ST_SYS;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			privMode <= 1'b1;
		end else begin
			privMode <= (state_nxt == ST_SYS);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Partition configuration, taken once after reset

	logic [MAW-1:0] testRomEnd_r;
	logic [MAW-1:0] secRowBase_r;
	logic [MAW-1:0] fabKeyLo_r;
	logic [MAW-1:0] fabKeyHi_r;
	logic [MAW-1:0] secRdLo_r;
	logic [MAW-1:0] secRdHi_r;

	// Frozen after the first load so software cannot move the bounds
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			cfgLoaded    <= 1'b0;
			testRomEnd_r <= `MBAC_RST_ADDR;
			secRowBase_r <= `MBAC_RST_ADDR;
			fabKeyLo_r   <= `MBAC_RST_ADDR;
			fabKeyHi_r   <= `MBAC_RST_ADDR;
			secRdLo_r    <= `MBAC_RST_ADDR;
			secRdHi_r    <= `MBAC_RST_ADDR;
		end else if (!cfgLoaded && cfgValid) begin
			cfgLoaded    <= 1'b1;
			testRomEnd_r <= cfgTestRomEnd;
			secRowBase_r <= cfgSecRowBase;
			fabKeyLo_r   <= cfgFabKeyLo;
			fabKeyHi_r   <= cfgFabKeyHi;
			secRdLo_r    <= cfgSecRdLo;
			secRdHi_r    <= cfgSecRdHi;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Memory permission

	logic inTestRom;
	logic inSecRow;
	logic inFabKey;
	logic inSecRd;
	logic memOk;

	assign inTestRom = memAddr < testRomEnd_r;
	assign inSecRow  = memAddr >= secRowBase_r;
	assign inFabKey  = (memAddr >= fabKeyLo_r) && (memAddr <= fabKeyHi_r);
	assign inSecRd   = (memAddr >= secRdLo_r) && (memAddr <= secRdHi_r);

	always_comb begin
		memOk = 1'b0;
		case (memSpace)
			SPC_ROM: begin
				if (memOp != OP_WRITE) begin
					memOk = isPriv || (isUsr && !inTestRom);
				end
			end
			SPC_EE: begin
				if (isPriv) begin
					memOk = 1'b1;
				end else if (isUsr && !inSecRow) begin
					memOk = (memOp != OP_EXEC);
				end else if (isUsr) begin
					memOk = (memOp == OP_READ) && (inFabKey || inSecRd);
				end
			end
			SPC_RAM: memOk = (isPriv || isUsr) && (memOp != OP_EXEC);
			default: memOk = 1'b0;
		endcase
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			memGrant <= 1'b0;
			memDeny  <= 1'b0;
		end else begin
			memGrant <= memReq && memOk;
			memDeny  <= memReq && !memOk;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register permission

	logic sfrImpl;
	logic sfrRdOk;
	logic sfrWrOk;
	logic rdAllowed;
	logic wrAllowed;

	mbac_sfr_perm #(
		.AW       (SAW)
	) uPerm (
		.sfrAddr  (sfrAddr),
		.privMode (isPriv),
		.sfrImpl  (sfrImpl),
		.sfrRdOk  (sfrRdOk),
		.sfrWrOk  (sfrWrOk)
	);

	// A halted core gets nothing, whatever the table says
	assign rdAllowed = sfrRdOk && !state_r[2];
	assign wrAllowed = sfrWrOk && !state_r[2];
	assign wrFault   = sfrReq && sfrWe && !wrAllowed;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			sfrAck   <= 1'b0;
			sfrRdata <= `MBAC_RST_DATA;
		end else begin
			sfrAck <= sfrReq;
			if (sfrReq && !sfrWe && rdAllowed) begin
				sfrRdata <= sfrRegData;
			end else begin
				sfrRdata <= `MBAC_RST_DATA;
			end
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			sfrWrStb  <= 1'b0;
			sfrWrAddr <= '0;
			sfrWrData <= `MBAC_RST_DATA;
		end else begin
			sfrWrStb <= sfrReq && sfrWe && wrAllowed;
			if (sfrReq && sfrWe && wrAllowed) begin
				sfrWrAddr <= sfrAddr;
				sfrWrData <= sfrWdata;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Security violation

	// Held until the system reset arrives; nothing else clears it
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			secViol   <= 1'b0;
			sysRstReq <= 1'b0;
		end else if (wrFault) begin
			secViol   <= 1'b1;
			sysRstReq <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!arst_n);

	sequence sDeniedWrite;
		sfrReq && sfrWe && !wrAllowed;
	endsequence

	sequence sViolHeld;
		(secViol && sysRstReq && !sfrWrStb) [*3];
	endsequence

	AST_BOOT_SWITCH: assert property (
		isPriv && bootDone && cfgLoaded && !wrFault |=> !privMode && isUsr
	) else $error("boot completion did not enter restricted mode");

	AST_NO_RETURN: assert property (
		!privMode |=> !privMode
	) else $error("returned to privileged mode without reset");

	AST_EE_EXEC: assert property (
		memReq && memSpace == SPC_EE && memOp == OP_EXEC && !isPriv
		|=> memDeny && !memGrant
	) else $error("EEPROM fetch granted outside privileged mode");

	AST_RD_ZERO: assert property (
		sfrReq && !sfrWe && !rdAllowed |=> sfrAck && sfrRdata == '0
	) else $error("denied register read returned nonzero data");

	AST_WR_VIOL: assert property (
		sDeniedWrite |=> sViolHeld
	) else $error("denied write did not raise violation and reset");

	AST_UNIMPL_WR: assert property (
		sfrReq && sfrWe && !sfrImpl |=> sysRstReq && !sfrWrStb
	) else $error("write to unimplemented register not treated as violation");

	AST_TEST_ROM: assert property (
		memReq && memSpace == SPC_ROM && inTestRom && isUsr |=> memDeny
	) else $error("test ROM reached in restricted mode");

	AST_RAM_OPEN: assert property (
		memReq && memSpace == SPC_RAM && memOp != OP_EXEC && isUsr |=> memGrant
	) else $error("RAM data access refused in restricted mode");

	AST_SECROW_WR: assert property (
		memReq && memSpace == SPC_EE && memOp == OP_WRITE && inSecRow && !isPriv
		|=> !memGrant
	) else $error("security row write granted in restricted mode");

	AST_KEY_UNREAD: assert property (
		sfrReq && !sfrWe && sfrAddr == `MBAC_SFR_CIPHER_KEY |=> sfrRdata == '0
	) else $error("key register contents leaked on read");

	AST_CFG_GROUP: assert property (
		sfrReq && sfrAddr >= `MBAC_SFR_CFG_LO && sfrAddr <= `MBAC_SFR_TEST_HI && isUsr
		|-> !sfrRdOk && !sfrWrOk
	) else $error("configuration or test group open in restricted mode");

	AST_PRIV_GROUPS: assert property (
		isPriv && sfrAddr >= `MBAC_SFR_CFG_LO && sfrAddr <= `MBAC_SFR_TEST_HI
		|-> sfrRdOk && sfrWrOk
	) else $error("configuration or test group closed in privileged mode");

	AST_RNG_RDONLY: assert property (
		sfrReq && sfrWe && sfrAddr == `MBAC_SFR_RNG_OUT |=> secViol && !sfrWrStb
	) else $error("write to random number register was accepted");

	AST_ROM_NO_WR: assert property (
		memReq && memSpace == SPC_ROM && memOp == OP_WRITE |=> memDeny && !memGrant
	) else $error("ROM write granted");

	AST_EE_PRIV: assert property (
		memReq && memSpace == SPC_EE && isPriv |=> memGrant && !memDeny
	) else $error("EEPROM access refused in privileged mode");

	AST_FABRICATION_KEY_AREA_RD: assert property (
		memReq && memSpace == SPC_EE && memOp == OP_READ && isUsr && inFabKey
		|=> memGrant
	) else $error("fabrication key area read refused in restricted mode");

	AST_CFG_FROZEN: assert property (
		cfgLoaded |=> cfgLoaded && $stable(testRomEnd_r) && $stable(secRowBase_r)
	) else $error("partition bounds moved after capture");

endmodule
`default_nettype wire
